// ===== logic/dcs_defs.vh
// Overview of operation
// - activate to activate or refresh: row cycle
// - refresh to activate or refresh: refresh cycle
// - activate to read or write: column delay
// - auto-precharge column command waits after activate
// - activates to different banks keep bank gap
// - write auto-precharge blocks bank for recovery+precharge
// - read waits turnaround after last write data
// - self refresh exit to non-read wait
// - self refresh exit to read: 200 cycles
// - refresh average interval 7.8 or 1.95 us
// - never more than eight refreshes outstanding
// - unstable clock power-down exit waits 200 cycles
// - row stays open row active minimum before precharge
//
// Purpose: constants for the ddr command spacing controller
// Assumes: times held in picoseconds except those marked in clocks, clock period in picoseconds
// Notes: cycle counts are derived in the modules from these figures
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH

// system clock period, 10 MHz
`define DCS_CLK_PS 100000
// least time in cycles, rounded up, never below one
`define DCS_CYC_UP(ps) ((((ps) + `DCS_CLK_PS - 1) / `DCS_CLK_PS) < 1 ? 1 : \
  (((ps) + `DCS_CLK_PS - 1) / `DCS_CLK_PS))
// longest time in cycles, rounded down
`define DCS_CYC_DN(ps) ((ps) / `DCS_CLK_PS)

// row_cycle_time, fast / slow grade
`define DCS_T_RC_F_PS 55000
`define DCS_T_RC_S_PS 60000
// refresh_cycle_time
`define DCS_T_RFC_F_PS 70000
`define DCS_T_RFC_S_PS 72000
// activate_to_column_delay and its auto-precharge twin
`define DCS_T_RCD_PS 15000
`define DCS_T_RAP_PS 15000
// precharge_period
`define DCS_T_RP_PS 15000
// bank_to_bank_activate_gap
`define DCS_T_RRD_F_PS 10000
`define DCS_T_RRD_S_PS 12000
// write_recovery_time
`define DCS_T_WR_PS 15000
// row_active_minimum
`define DCS_T_RAS_F_PS 40000
`define DCS_T_RAS_S_PS 42000
// self_exit_to_nonread
`define DCS_T_XSNR_PS 70000
// write_to_read_turnaround, in clocks
`define DCS_WTR_F_CLK 2
`define DCS_WTR_S_CLK 1
// self_exit_to_read and powerdown_exit_delay, in clocks
`define DCS_XSRD_CLK 200
`define DCS_XPRD_CLK 200
// average_refresh_interval, normal / hot (7.8 us, 1.95 us)
`define DCS_T_REFI_PS 7800000
`define DCS_T_REFI_HOT_PS 1950000
// most refreshes that may be owed
`define DCS_REF_MAX 4'h8

// command codes
`define DCS_CMD_NOP 4'h0
`define DCS_CMD_ACT 4'h1
`define DCS_CMD_RD 4'h2
`define DCS_CMD_WR 4'h3
`define DCS_CMD_PRE 4'h4
`define DCS_CMD_REF 4'h5
`define DCS_CMD_SRE 4'h6
`define DCS_CMD_SRX 4'h7
`define DCS_CMD_PDE 4'h8
`define DCS_CMD_PDX 4'h9

`endif

// ===== logic/dcs_cnt.v
// Purpose: down counter that holds off a command until it reaches zero
// Assumes: load and count on the same system clock
// Notes: a load never shortens a wait already running
`timescale 1ns/1ns
`default_nettype none

module dcs_cnt #(
  parameter W = 8
) (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_load,
  input wire [W-1:0] i_value,
  output wire o_zero
);

  reg [W-1:0] cnt_q; // cycles still to wait

  // keep the longer of the running and the new wait
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cnt_q <= {W{1'b0}};
    end else if (i_load && (i_value > cnt_q)) begin
      cnt_q <= i_value;
    end else if (cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign o_zero = (cnt_q == {W{1'b0}});

endmodule

`default_nettype wire

// ===== logic/dcs_ctrl.v
// Purpose: ddr command issuer that keeps every command spacing limit
// Assumes: device command pins abstracted as code, bank and ap flag
// Notes: refreshes are generated here; the user never asks for them
`timescale 1ns/1ns
`default_nettype none
`include "dcs_defs.vh"

module dcs_ctrl #(
  parameter [7:0] P_WR_DATA_CYC = 8'h03, // write command to last data
  parameter [7:0] P_RD_BURST_CYC = 8'h02 // read burst length in clocks
) (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_grade_fast,
  input wire i_hot,
  input wire i_clk_unstable,
  input wire i_req_valid,
  input wire [3:0] i_req_cmd,
  input wire [1:0] i_req_bank,
  input wire i_req_ap,
  output reg o_req_ack,
  output reg o_cmd_valid,
  output reg [3:0] o_cmd_code,
  output reg [1:0] o_cmd_bank,
  output reg o_cmd_ap,
  output reg o_cke,
  output reg [3:0] o_ref_owed,
  output reg o_ref_late
);

  // operating states
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_SELF = 2'h1;
  localparam [1:0] ST_PDN = 2'h2;

  // cycle counts, ps minimums rounded up, refresh intervals rounded down
  localparam integer K_RC_F = `DCS_CYC_UP(`DCS_T_RC_F_PS);
  localparam integer K_RC_S = `DCS_CYC_UP(`DCS_T_RC_S_PS);
  localparam integer K_RFC_F = `DCS_CYC_UP(`DCS_T_RFC_F_PS);
  localparam integer K_RFC_S = `DCS_CYC_UP(`DCS_T_RFC_S_PS);
  localparam integer K_RCD = `DCS_CYC_UP(`DCS_T_RCD_PS);
  localparam integer K_RAP = `DCS_CYC_UP(`DCS_T_RAP_PS);
  localparam integer K_RP = `DCS_CYC_UP(`DCS_T_RP_PS);
  localparam integer K_RRD_F = `DCS_CYC_UP(`DCS_T_RRD_F_PS);
  localparam integer K_RRD_S = `DCS_CYC_UP(`DCS_T_RRD_S_PS);
  localparam integer K_WR = `DCS_CYC_UP(`DCS_T_WR_PS);
  localparam integer K_RAS_F = `DCS_CYC_UP(`DCS_T_RAS_F_PS);
  localparam integer K_RAS_S = `DCS_CYC_UP(`DCS_T_RAS_S_PS);
  localparam integer K_XSNR = `DCS_CYC_UP(`DCS_T_XSNR_PS);
  localparam integer K_REFI = `DCS_CYC_DN(`DCS_T_REFI_PS);
  localparam integer K_REFI_HOT = `DCS_CYC_DN(`DCS_T_REFI_HOT_PS);
  localparam integer K_WTR_F = `DCS_WTR_F_CLK;
  localparam integer K_WTR_S = `DCS_WTR_S_CLK;
  localparam integer K_XSRD = `DCS_XSRD_CLK;
  localparam integer K_XPRD = `DCS_XPRD_CLK;
  localparam integer K_ONE = 1;
  localparam integer K_COL = (K_RCD > K_RAP) ? K_RCD : K_RAP;

  // waits: five grade-selected, refresh interval by i_hot, the rest fixed
  wire [7:0] c_rc; // row cycle
  wire [7:0] c_rfc; // refresh cycle
  wire [7:0] c_rrd; // bank to bank activate gap
  wire [7:0] c_ras; // row active minimum
  wire [7:0] c_wtr; // write to read turnaround
  wire [7:0] c_col; // activate to column, plain or auto-precharge
  wire [7:0] c_rp; // precharge period
  wire [7:0] c_dal; // auto-precharge write total
  wire [7:0] c_rdap; // read auto-precharge hold-off
  wire [7:0] c_refi; // refresh interval

  assign c_rc = i_grade_fast ? K_RC_F[7:0] : K_RC_S[7:0];
  assign c_rfc = i_grade_fast ? K_RFC_F[7:0] : K_RFC_S[7:0];
  assign c_rrd = i_grade_fast ? K_RRD_F[7:0] : K_RRD_S[7:0];
  assign c_ras = i_grade_fast ? K_RAS_F[7:0] : K_RAS_S[7:0];
  assign c_wtr = i_grade_fast ? K_WTR_F[7:0] : K_WTR_S[7:0];
  assign c_col = K_COL[7:0];
  assign c_rp = K_RP[7:0];
  assign c_dal = P_WR_DATA_CYC + K_WR[7:0] + K_RP[7:0];
  assign c_rdap = P_RD_BURST_CYC + K_RP[7:0];
  assign c_refi = i_hot ? K_REFI_HOT[7:0] : K_REFI[7:0];

  // issue decision of this cycle
  reg iss; // a command goes out at this edge
  reg [3:0] iss_cmd; // its code
  reg [1:0] iss_bank; // its bank
  reg iss_ap; // its auto-precharge flag
  reg iss_user; // it came from the user port

  reg [1:0] st_q; // operating state
  reg [3:0] open_q; // one bit per bank, row open
  reg [7:0] refi_q; // cycles to the next refresh tick
  reg [3:0] owed_q; // refreshes owed

  wire [3:0] rc_zero; // per bank row cycle over
  wire [3:0] ras_zero; // per bank row active minimum over
  wire [3:0] col_zero; // per bank column delay over
  wire [3:0] pre_zero; // per bank precharge or recovery over
  wire rrd_zero; // bank gap over
  wire rfc_zero; // refresh cycle over
  wire wtr_zero; // write to read over
  wire xsnr_zero; // self exit non-read over
  wire xsrd_zero; // self exit read over
  wire xprd_zero; // power-down exit over

  // per-bank timers, loaded by the command that starts each wait
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_bank
      wire act_b; // activate to this bank
      wire pre_b; // explicit precharge to this bank
      wire wap_b; // write with auto-precharge to this bank
      wire rap_b; // read with auto-precharge to this bank
      assign act_b = iss && (iss_cmd == `DCS_CMD_ACT) && (iss_bank == b);
      assign pre_b = iss && (iss_cmd == `DCS_CMD_PRE) && (iss_bank == b);
      assign wap_b = iss && (iss_cmd == `DCS_CMD_WR) && iss_ap &&
        (iss_bank == b);
      assign rap_b = iss && (iss_cmd == `DCS_CMD_RD) && iss_ap &&
        (iss_bank == b);
      // row cycle from activate
      dcs_cnt #(.W(8)) u_rc (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_load(act_b),
        .i_value(c_rc), .o_zero(rc_zero[b]));
      // row held open at least the minimum
      dcs_cnt #(.W(8)) u_ras (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_load(act_b),
        .i_value(c_ras), .o_zero(ras_zero[b]));
      // column command delay, plain and auto-precharge
      dcs_cnt #(.W(8)) u_col (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_load(act_b),
        .i_value(c_col), .o_zero(col_zero[b]));
      // precharge, or write recovery plus precharge
      dcs_cnt #(.W(8)) u_pre (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_load(pre_b | wap_b | rap_b),
        .i_value(wap_b ? c_dal : (rap_b ? c_rdap : c_rp)),
        .o_zero(pre_zero[b]));
    end
  endgenerate

  // device-wide timers
  wire any_act; // activate to any bank
  wire is_wr; // write to any bank
  assign any_act = iss && (iss_cmd == `DCS_CMD_ACT);
  assign is_wr = iss && (iss_cmd == `DCS_CMD_WR);

  // bank to bank activate gap
  dcs_cnt #(.W(8)) u_rrd (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_load(any_act),
    .i_value(c_rrd), .o_zero(rrd_zero));
  // refresh cycle
  dcs_cnt #(.W(8)) u_rfc (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_load(iss && (iss_cmd == `DCS_CMD_REF)),
    .i_value(c_rfc), .o_zero(rfc_zero));
  // last write data plus turnaround before a read
  dcs_cnt #(.W(8)) u_wtr (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_load(is_wr),
    .i_value(P_WR_DATA_CYC + c_wtr), .o_zero(wtr_zero));
  // self refresh exit to non-read
  dcs_cnt #(.W(8)) u_xsnr (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_load(iss && (iss_cmd == `DCS_CMD_SRX)),
    .i_value(K_XSNR[7:0]), .o_zero(xsnr_zero));
  // self refresh exit to read, dll relock
  dcs_cnt #(.W(8)) u_xsrd (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_load(iss && (iss_cmd == `DCS_CMD_SRX)),
    .i_value(K_XSRD[7:0]), .o_zero(xsrd_zero));
  // power-down exit, long when the clock wandered
  dcs_cnt #(.W(8)) u_xprd (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_load(iss && (iss_cmd == `DCS_CMD_PDX)),
    .i_value(i_clk_unstable ? K_XPRD[7:0] : K_ONE[7:0]),
    .o_zero(xprd_zero));

  // banks quiet enough for refresh or self refresh entry
  wire all_idle; // no row open and every bank's row cycle and precharge waits over
  wire run_ok; // running and out of power-down exit wait
  wire ref_ok; // a refresh may go out now
  wire ref_full; // owed count at its ceiling
  assign all_idle = (open_q == 4'h0) && (&rc_zero) && (&pre_zero);
  assign run_ok = (st_q == ST_RUN) && xprd_zero;
  assign ref_ok = run_ok && all_idle && rfc_zero && xsnr_zero;
  assign ref_full = (owed_q == `DCS_REF_MAX);

  // legality of the user request against every running wait
  reg user_ok; // request may go out now
  always @* begin
    user_ok = 1'b0;
    case (i_req_cmd)
      `DCS_CMD_ACT: begin
        // activate held off while refreshes are at the ceiling
        user_ok = run_ok && xsnr_zero && !open_q[i_req_bank] &&
          rc_zero[i_req_bank] && pre_zero[i_req_bank] && rrd_zero &&
          rfc_zero && !ref_full;
      end
      `DCS_CMD_RD: begin
        user_ok = run_ok && open_q[i_req_bank] &&
          col_zero[i_req_bank] && wtr_zero && xsrd_zero;
      end
      `DCS_CMD_WR: begin
        user_ok = run_ok && xsnr_zero && open_q[i_req_bank] &&
          col_zero[i_req_bank];
      end
      `DCS_CMD_PRE: begin
        user_ok = run_ok && xsnr_zero && open_q[i_req_bank] &&
          ras_zero[i_req_bank];
      end
      `DCS_CMD_SRE: begin
        user_ok = ref_ok;
      end
      `DCS_CMD_SRX: begin
        user_ok = (st_q == ST_SELF);
      end
      `DCS_CMD_PDE: begin
        user_ok = run_ok && xsnr_zero;
      end
      `DCS_CMD_PDX: begin
        user_ok = (st_q == ST_PDN);
      end
      default: begin
        user_ok = 1'b0;
      end
    endcase
  end

  // arbitration: owed refresh first when at ceiling or user idle
  always @* begin
    iss = 1'b0;
    iss_cmd = `DCS_CMD_NOP;
    iss_bank = 2'h0;
    iss_ap = 1'b0;
    iss_user = 1'b0;
    if (ref_ok && (owed_q != 4'h0) &&
        (ref_full || !i_req_valid || o_req_ack)) begin
      iss = 1'b1;
      iss_cmd = `DCS_CMD_REF;
    end else if (i_req_valid && !o_req_ack && user_ok) begin
      iss = 1'b1;
      iss_cmd = i_req_cmd;
      iss_bank = i_req_bank;
      iss_ap = i_req_ap &&
        ((i_req_cmd == `DCS_CMD_RD) || (i_req_cmd == `DCS_CMD_WR));
      iss_user = 1'b1;
    end
  end

  // refresh interval tick and owed count
  wire tick; // one interval has passed
  assign tick = (refi_q == 8'h00) && (st_q != ST_SELF);
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      refi_q <= 8'h00;
      owed_q <= 4'h0;
      o_ref_late <= 1'b0;
    end else begin
      // device refreshes itself in self refresh, so the interval rests
      if (st_q == ST_SELF) begin
        refi_q <= c_refi - 8'h01;
      end else if (tick) begin
        refi_q <= c_refi - 8'h01;
      end else begin
        refi_q <= refi_q - 8'h01;
      end
      // a tick at the ceiling is lost and flagged, never a ninth
      if (tick && ref_full && !(iss && iss_cmd == `DCS_CMD_REF)) begin
        o_ref_late <= 1'b1;
      end
      if (tick && !(iss && iss_cmd == `DCS_CMD_REF) && !ref_full) begin
        owed_q <= owed_q + 4'h1;
      end else if (!tick && iss && iss_cmd == `DCS_CMD_REF) begin
        owed_q <= owed_q - 4'h1;
      end
    end
  end

  // row open flags and operating state
  integer i;
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      open_q <= 4'h0;
      st_q <= ST_RUN;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (iss && (iss_bank == i)) begin
          if (iss_cmd == `DCS_CMD_ACT) begin
            open_q[i] <= 1'b1;
          end else if ((iss_cmd == `DCS_CMD_PRE) || iss_ap) begin
            open_q[i] <= 1'b0;
          end
        end
      end
      if (iss) begin
        case (iss_cmd)
          `DCS_CMD_SRE: st_q <= ST_SELF;
          `DCS_CMD_PDE: st_q <= ST_PDN;
          `DCS_CMD_SRX: st_q <= ST_RUN;
          `DCS_CMD_PDX: st_q <= ST_RUN;
          default: st_q <= st_q;
        endcase
      end
    end
  end

  // registered command pins and user answer
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_req_ack <= 1'b0;
      o_cmd_valid <= 1'b0;
      o_cmd_code <= `DCS_CMD_NOP;
      o_cmd_bank <= 2'h0;
      o_cmd_ap <= 1'b0;
      o_cke <= 1'b1;
      o_ref_owed <= 4'h0;
    end else begin
      o_req_ack <= iss_user;
      o_cmd_valid <= iss;
      o_cmd_code <= iss_cmd;
      o_cmd_bank <= iss_bank;
      o_cmd_ap <= iss_ap;
      // clock enable low in self refresh and power-down
      if (iss && (iss_cmd == `DCS_CMD_SRE || iss_cmd == `DCS_CMD_PDE)) begin
        o_cke <= 1'b0;
      end else if (iss &&
          (iss_cmd == `DCS_CMD_SRX || iss_cmd == `DCS_CMD_PDX)) begin
        o_cke <= 1'b1;
      end
      o_ref_owed <= owed_q;
    end
  end

endmodule

`default_nettype wire

// ===== verif/dcs_ctrl_asserts.sv
// Purpose: spacing checks on the command issuer ports
// Assumes: default burst and write data parameters
// Notes: exit and write helper counters saturate at 255; the refresh interval counter ri_q wraps
`timescale 1ns/1ns
`default_nettype none
`include "dcs_defs.vh"
module dcs_ctrl_chk #(
  parameter [7:0] P_WR_DATA_CYC = 8'h03,
  parameter [7:0] P_RD_BURST_CYC = 8'h02
) (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_grade_fast,
  input wire i_hot,
  input wire i_clk_unstable,
  input wire i_req_valid,
  input wire [3:0] i_req_cmd,
  input wire [1:0] i_req_bank,
  input wire i_req_ap,
  input wire o_req_ack,
  input wire o_cmd_valid,
  input wire [3:0] o_cmd_code,
  input wire [1:0] o_cmd_bank,
  input wire o_cmd_ap,
  input wire o_cke,
  input wire [3:0] o_ref_owed,
  input wire o_ref_late
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // decoded command pulses
  wire wr = o_cmd_valid && o_cmd_code == `DCS_CMD_WR;
  wire rd = o_cmd_valid && o_cmd_code == `DCS_CMD_RD;
  wire act = o_cmd_valid && o_cmd_code == `DCS_CMD_ACT;
  wire rf = o_cmd_valid && o_cmd_code == `DCS_CMD_REF;
  wire srx = o_cmd_valid && o_cmd_code == `DCS_CMD_SRX;
  wire pdx = o_cmd_valid && o_cmd_code == `DCS_CMD_PDX;
  // cycles since exits, refresh events and precharging writes
  reg [7:0] xs_q;
  reg [7:0] xp_q;
  reg [7:0] ri_q;
  reg [3:0] owed_q;
  reg [7:0] dal_q [0:3];
  integer k;
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      xs_q <= 8'hff;
      xp_q <= 8'hff;
      ri_q <= 8'h00;
      owed_q <= 4'h0;
      for (k = 0; k < 4; k = k + 1)
        dal_q[k] <= 8'hff;
    end else begin
      xs_q <= srx ? 8'h01 : xs_q + {7'h00, xs_q != 8'hff};
      xp_q <= (pdx && i_clk_unstable) ? 8'h01 :
        xp_q + {7'h00, xp_q != 8'hff};
      owed_q <= o_ref_owed;
      // any refresh event or paused interval restarts the count
      ri_q <= (rf || o_ref_owed != owed_q || !o_cke || !i_hot ||
        o_ref_owed == 4'h8) ? 8'h00 : ri_q + 8'h01;
      for (k = 0; k < 4; k = k + 1)
        dal_q[k] <= (wr && o_cmd_ap && o_cmd_bank == k) ? 8'h01 :
          dal_q[k] + {7'h00, dal_q[k] != 8'hff};
    end
  end
  sequence s_wr_fast;
    wr && i_grade_fast;
  endsequence
  sequence s_wr_slow;
    wr && !i_grade_fast;
  endsequence
  chk_owed_max: assert property (o_ref_owed <= 4'h8)
    else $error("refresh owed count above eight");
  chk_wtr_fast: assert property (s_wr_fast |=> !rd [*4])
    else $error("read too close to write, fast grade");
  chk_wtr_slow: assert property (s_wr_slow |=> !rd [*3])
    else $error("read too close to write, slow grade");
  chk_dal_gap: assert property (act |-> dal_q[o_cmd_bank] >=
    P_WR_DATA_CYC + 8'h02)
    else $error("activate too close to precharging write");
  chk_xsrd_gap: assert property (rd |-> xs_q >= 8'hc8)
    else $error("read too close to self refresh exit");
  chk_xprd_gap: assert property (o_cmd_valid |-> xp_q >= 8'hc8)
    else $error("command too close to power-down exit");
  chk_ref_rate: assert property (i_hot |-> ri_q <= 8'h13)
    else $error("refresh interval too long");
  chk_ack_cmd: assert property (o_req_ack |-> o_cmd_valid &&
    o_cmd_code == $past(i_req_cmd) && o_cmd_bank == $past(i_req_bank))
    else $error("acknowledge without the asked command");
endmodule
bind dcs_ctrl dcs_ctrl_chk #(
  .P_WR_DATA_CYC(P_WR_DATA_CYC),
  .P_RD_BURST_CYC(P_RD_BURST_CYC)
) dcs_ctrl_chk_i (
  .i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n),
  .i_grade_fast(i_grade_fast),
  .i_hot(i_hot),
  .i_clk_unstable(i_clk_unstable),
  .i_req_valid(i_req_valid),
  .i_req_cmd(i_req_cmd),
  .i_req_bank(i_req_bank),
  .i_req_ap(i_req_ap),
  .o_req_ack(o_req_ack),
  .o_cmd_valid(o_cmd_valid),
  .o_cmd_code(o_cmd_code),
  .o_cmd_bank(o_cmd_bank),
  .o_cmd_ap(o_cmd_ap),
  .o_cke(o_cke),
  .o_ref_owed(o_ref_owed),
  .o_ref_late(o_ref_late)
);
`default_nettype wire

// ===== verif/dcs_dev_model.sv
// Purpose: memory device that counts spacing violations it receives
// Assumes: one command pulse per clock, times in ns
// Notes: data bursts are not modelled
`timescale 1ns/1ns
`default_nettype none
`include "dcs_defs.vh"
module dcs_dev_model (
  input wire i_clk_sys,
  input wire i_grade_fast,
  input wire i_cmd_valid,
  input wire [3:0] i_cmd_code,
  input wire [1:0] i_cmd_bank,
  input wire i_cmd_ap,
  output var int o_viol
);
  bit [3:0] open_q = 4'h0; // rows held open
  realtime t_act [4] = '{default: -1e6};
  realtime t_wa [4] = '{default: -1e6};
  realtime t_any = -1e6, t_ref = -1e6, t_srx = -1e6, d;
  initial o_viol = 0;
  task chk(input bit ok);
    if (!ok) o_viol++;
  endtask
  // each command is held against the bank, refresh or self refresh exit timers
  always @(posedge i_clk_sys) if (i_cmd_valid === 1'b1) begin
    d = $realtime;
    if (i_cmd_code != `DCS_CMD_RD) chk(d - t_srx >= 70);
    case (i_cmd_code)
      `DCS_CMD_ACT: begin
        chk(!open_q[i_cmd_bank]);
        chk(d - t_act[i_cmd_bank] >= (i_grade_fast ? 55 : 60));
        chk(d - t_any >= (i_grade_fast ? 10 : 12));
        chk(d - t_ref >= (i_grade_fast ? 70 : 72));
        chk(d - t_wa[i_cmd_bank] >= 30);
        open_q[i_cmd_bank] = 1'b1;
        t_act[i_cmd_bank] = d;
        t_any = d;
      end
      `DCS_CMD_RD, `DCS_CMD_WR: begin
        chk(open_q[i_cmd_bank]);
        chk(d - t_act[i_cmd_bank] >= 15);
        if (i_cmd_ap) open_q[i_cmd_bank] = 1'b0;
        if (i_cmd_ap && i_cmd_code == `DCS_CMD_WR) t_wa[i_cmd_bank] = d;
      end
      `DCS_CMD_PRE: begin
        chk(d - t_act[i_cmd_bank] >= (i_grade_fast ? 40 : 42));
        open_q[i_cmd_bank] = 1'b0;
      end
      `DCS_CMD_REF: begin
        chk(open_q == 4'h0);
        chk(d - t_ref >= (i_grade_fast ? 70 : 72));
        chk(d - t_any >= (i_grade_fast ? 55 : 60));
        t_ref = d;
      end
      `DCS_CMD_SRX: t_srx = d;
      default: ;
    endcase
  end
endmodule
`default_nettype wire

// ===== verif/test_ddr_command_spacing_rules.sv
// Purpose: self-checking bench for the command issuer
// Assumes: default parameters, 10 MHz clock
// Notes: expected commands are queued as they are asked for
`timescale 1ns/1ns
`default_nettype none
`include "dcs_defs.vh"
module test_ddr_command_spacing_rules;
  logic i_clk_sys = 0, i_rst_n = 0, i_grade_fast = 0, i_hot = 0;
  logic i_clk_unstable = 0, i_req_valid = 0, i_req_ap = 0;
  logic [3:0] i_req_cmd = 4'h0;
  logic [1:0] i_req_bank = 2'h0, b;
  wire o_req_ack, o_cmd_valid, o_cmd_ap, o_cke, o_ref_late;
  wire [3:0] o_cmd_code, o_ref_owed;
  wire [1:0] o_cmd_bank;
  int num_errors = 0, num_checks = 0, viol, cyc = 0, nref = 0, r0;
  int t_wr = -999, t_srx = -999, t_pdx = -999;
  int t_wa [4] = '{default: -999};
  int t_ra [4] = '{default: -999};
  logic [6:0] exp_q [$]; // code, bank, ap of asked commands
  logic [31:0] rng = 32'h0001398b;
  always #50 i_clk_sys = ~i_clk_sys;
  dcs_ctrl dcs_ctrl_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_grade_fast(i_grade_fast), .i_hot(i_hot),
    .i_clk_unstable(i_clk_unstable), .i_req_valid(i_req_valid),
    .i_req_cmd(i_req_cmd), .i_req_bank(i_req_bank), .i_req_ap(i_req_ap),
    .o_req_ack(o_req_ack), .o_cmd_valid(o_cmd_valid),
    .o_cmd_code(o_cmd_code), .o_cmd_bank(o_cmd_bank),
    .o_cmd_ap(o_cmd_ap), .o_cke(o_cke), .o_ref_owed(o_ref_owed),
    .o_ref_late(o_ref_late));
  dcs_dev_model dcs_dev_model_i (.i_clk_sys(i_clk_sys),
    .i_grade_fast(i_grade_fast), .i_cmd_valid(o_cmd_valid),
    .i_cmd_code(o_cmd_code), .i_cmd_bank(o_cmd_bank),
    .i_cmd_ap(o_cmd_ap), .o_viol(viol));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  task check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task give_verdict;
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hold a request until it is acknowledged
  task issue(input logic [3:0] c, input logic [1:0] k, input logic a);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    exp_q.push_back({c, k, a});
    i_req_valid <= 1'b1;
    i_req_cmd <= c;
    i_req_bank <= k;
    i_req_ap <= a;
    @(posedge i_clk_sys);
    while (o_req_ack !== 1'b1 && n < 2000) begin
      @(posedge i_clk_sys);
      n++;
    end
    check(n < 2000, "request never taken");
    i_req_valid <= 1'b0;
  endtask
  // reference of the command stream and the least gaps between commands
  always @(posedge i_clk_sys) begin
    cyc++;
    if (o_cmd_valid === 1'b1) begin
      check(cyc - t_pdx >= 200, "power-down exit gap");
      if (o_cmd_code === `DCS_CMD_REF) nref++;
      else begin
        check({o_cmd_code, o_cmd_bank, o_cmd_ap} === exp_q[0], "command");
        void'(exp_q.pop_front());
      end
      if (o_cmd_code === `DCS_CMD_RD) begin
        check(cyc - t_wr >= (i_grade_fast ? 5 : 4), "turnaround");
        check(cyc - t_srx >= 200, "exit to read gap");
        if (o_cmd_ap === 1'b1) t_ra[o_cmd_bank] = cyc;
      end
      if (o_cmd_code === `DCS_CMD_ACT) begin
        check(cyc - t_wa[o_cmd_bank] >= 5, "write recovery gap");
        check(cyc - t_ra[o_cmd_bank] >= 3, "read precharge gap");
      end
      if (o_cmd_code === `DCS_CMD_WR) t_wr = cyc;
      if (o_cmd_code === `DCS_CMD_WR && o_cmd_ap === 1'b1)
        t_wa[o_cmd_bank] = cyc;
      if (o_cmd_code === `DCS_CMD_SRX) t_srx = cyc;
      if (o_cmd_code === `DCS_CMD_PDX && i_clk_unstable) t_pdx = cyc;
    end
  end
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    num_errors++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    // random bank, both grades in turn, back-to-back column traffic
    for (int n = 0; n < 6; n++) begin
      rng = xs(rng);
      i_grade_fast <= n[0];
      b = rng[2:1];
      issue(`DCS_CMD_ACT, b, 1'b0);
      issue(`DCS_CMD_WR, b, 1'b0);
      issue(`DCS_CMD_RD, b, 1'b0);
      issue(`DCS_CMD_WR, b, 1'b1);
      issue(`DCS_CMD_ACT, b, 1'b0);
      issue(`DCS_CMD_RD, b, 1'b1);
      issue(`DCS_CMD_ACT, b, 1'b0);
      issue(`DCS_CMD_PRE, b, 1'b0);
    end
    // self refresh round trip, read waits for the lock
    issue(`DCS_CMD_SRE, 2'h0, 1'b0);
    repeat (40) @(posedge i_clk_sys);
    check(o_cke === 1'b0, "clock enable in self refresh");
    issue(`DCS_CMD_SRX, 2'h0, 1'b0);
    issue(`DCS_CMD_ACT, 2'h0, 1'b0);
    issue(`DCS_CMD_RD, 2'h0, 1'b0);
    issue(`DCS_CMD_PRE, 2'h0, 1'b0);
    // second reset: hot interval, unstable clock in power-down
    i_rst_n <= 1'b0;
    i_hot <= 1'b1;
    i_clk_unstable <= 1'b1;
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    issue(`DCS_CMD_PDE, 2'h0, 1'b0);
    repeat (250) @(posedge i_clk_sys);
    check(o_ref_owed === 4'h8 && o_ref_late === 1'b1, "owed cap");
    check(o_cke === 1'b0, "clock enable in power-down");
    issue(`DCS_CMD_PDX, 2'h0, 1'b0);
    issue(`DCS_CMD_ACT, 2'h1, 1'b0);
    issue(`DCS_CMD_PRE, 2'h1, 1'b0);
    // stable clock: the power-down exit wait is short
    i_clk_unstable <= 1'b0;
    issue(`DCS_CMD_PDE, 2'h0, 1'b0);
    issue(`DCS_CMD_PDX, 2'h0, 1'b0);
    r0 = cyc;
    issue(`DCS_CMD_ACT, 2'h2, 1'b0);
    check(cyc - r0 < 12, "stable power-down exit");
    issue(`DCS_CMD_PRE, 2'h2, 1'b0);
    r0 = nref;
    repeat (380) @(posedge i_clk_sys);
    check(nref - r0 >= 20, "refresh rate");
    check(o_ref_owed <= 4'h1, "owed refreshes drained");
    check(viol == 0 && exp_q.size() == 0 && o_cke === 1'b1, "device or stream");
    give_verdict;
  end
endmodule
`default_nettype wire
